/* caregs_pkg.sv */
// Package for the current alert status register bank
package caregs_pkg;
	localparam int          CAREGS_NUM_CHAN    = 8;
	localparam int          CAREGS_CHAN_W      = 3;
	localparam int          CAREGS_ADDR_W      = 8;
	localparam int          CAREGS_DATA_W      = 8;
	localparam logic [7:0]  CAREGS_OFF_LOW     = 8'h7c;
	localparam logic [7:0]  CAREGS_OFF_HIGH    = 8'h7d;
	localparam logic [7:0]  CAREGS_OFF_ANY     = 8'h7e;
	localparam logic [7:0]  CAREGS_RESET_VAL   = 8'h00;
	localparam logic [7:0]  CAREGS_UNMAPPED    = 8'h00;
endpackage : caregs_pkg

/* caregs_flag_bank.sv */
// Per-channel flag bank refreshed by each conversion
`timescale 1ns/1ps
module caregs_flag_bank
(
	// Clock and reset
	input  wire logic                                 sys_clk_in,
	input  wire logic                                 rst_in,
	// Conversion result
	input  wire logic                                 conv_done_in,
	input  wire logic [caregs_pkg::CAREGS_CHAN_W-1:0] input_channel_in,
	input  wire logic                                 hit_in,
	// Flags
	output logic [caregs_pkg::CAREGS_NUM_CHAN-1:0]    flags_out
);
	import caregs_pkg::*;

	logic [CAREGS_NUM_CHAN-1:0] flags_r;
	logic [CAREGS_NUM_CHAN-1:0] flags_nxt;
	logic [CAREGS_NUM_CHAN-1:0] sel_mask;

	assign sel_mask  = CAREGS_NUM_CHAN'(1) << input_channel_in;
	assign flags_nxt = hit_in ? (flags_r | sel_mask)
	                          : (flags_r & ~sel_mask);
	assign flags_out = flags_r;

	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
			flags_r <= CAREGS_RESET_VAL;
		else if (conv_done_in)
			flags_r <= flags_nxt;
	end
endmodule : caregs_flag_bank

/* caregs_top.sv */
// Current alert status registers: low, high and combined per channel
// Behaviour
// - Low-alert register: bit n is channel n
// - High-alert register: bit n is channel n
// - Low bit is 1 when low crossed
// - High bit is 1 when high crossed
// - Combined bit is OR of high, low
// - Combined bit 0 only if neither crossed
// - A channel's bits refresh after each completed conversion of that channel; other bits hold
// - Reset clears all three registers
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
module caregs_top
(
	// Clock and reset
	input  wire logic                                 sys_clk_in,
	input  wire logic                                 rst_in,

	// Window comparator result, same clock domain
	input  wire logic                                 conv_done_in,
	input  wire logic [caregs_pkg::CAREGS_CHAN_W-1:0] input_channel_in,
	input  wire logic                                 chan_low_hit_in,
	input  wire logic                                 chan_high_hit_in,

	// Register port
	input  wire logic [caregs_pkg::CAREGS_ADDR_W-1:0] reg_addr_in,
	input  wire logic [caregs_pkg::CAREGS_DATA_W-1:0] reg_wdata_in,
	input  wire logic                                 reg_wr_in,
	input  wire logic                                 reg_rd_in,
	output logic [caregs_pkg::CAREGS_DATA_W-1:0]      reg_rdata_out,

	// Live combined flags
	output logic [caregs_pkg::CAREGS_NUM_CHAN-1:0]    chan_any_hit_out
);
	import caregs_pkg::*;

	// ==========================================================
	// Helper functions

	// True when the port address names the given register
	function automatic logic addr_is
	(
		input logic [CAREGS_ADDR_W-1:0] addr,
		input logic [CAREGS_ADDR_W-1:0] offset
	);
	begin
		addr_is = (addr == offset);
	end
	endfunction : addr_is

	// Passes a register byte only while its select is high
	function automatic logic [CAREGS_DATA_W-1:0] gate_byte
	(
		input logic                     sel,
		input logic [CAREGS_DATA_W-1:0] data
	);
	begin
		if (sel)
		begin
			gate_byte = data;
		end
		else
		begin
			gate_byte = CAREGS_UNMAPPED;
		end
	end
	endfunction : gate_byte

	// Widens or trims a flag vector to the register width
	function automatic logic [CAREGS_DATA_W-1:0] flags_view
	(
		input logic [CAREGS_NUM_CHAN-1:0] flags
	);
	begin
		flags_view = CAREGS_DATA_W'(flags);
	end
	endfunction : flags_view

	// ==========================================================
	// Conversion inputs

	logic conv_either;

	// Either threshold crossed by this conversion
	assign conv_either = chan_low_hit_in | chan_high_hit_in;

	// ==========================================================
	// Flag banks, one per register

	logic [CAREGS_NUM_CHAN-1:0] low_flags;
	logic [CAREGS_NUM_CHAN-1:0] high_flags;
	logic [CAREGS_NUM_CHAN-1:0] any_flags;

	// Low-threshold flags
	caregs_flag_bank u_low
	(
		.sys_clk_in       (sys_clk_in),
		.rst_in           (rst_in),
		.conv_done_in     (conv_done_in),
		.input_channel_in (input_channel_in),
		.hit_in           (chan_low_hit_in),
		.flags_out        (low_flags)
	);

	// High-threshold flags
	caregs_flag_bank u_high
	(
		.sys_clk_in       (sys_clk_in),
		.rst_in           (rst_in),
		.conv_done_in     (conv_done_in),
		.input_channel_in (input_channel_in),
		.hit_in           (chan_high_hit_in),
		.flags_out        (high_flags)
	);

	// Combined flags; same refresh as the others keeps the OR exact
	caregs_flag_bank u_any
	(
		.sys_clk_in       (sys_clk_in),
		.rst_in           (rst_in),
		.conv_done_in     (conv_done_in),
		.input_channel_in (input_channel_in),
		.hit_in           (conv_either),
		.flags_out        (any_flags)
	);

	// ==========================================================
	// Register views

	logic [CAREGS_DATA_W-1:0] low_view;
	logic [CAREGS_DATA_W-1:0] high_view;
	logic [CAREGS_DATA_W-1:0] any_view;

	assign low_view  = flags_view(low_flags);
	assign high_view = flags_view(high_flags);
	assign any_view  = flags_view(any_flags);

	// ==========================================================
	// Write side

	// Registers are read-only: no write reaches a flop
	logic wr_discard;

	assign wr_discard = reg_wr_in & (|reg_wdata_in);

	// ==========================================================
	// Read decode

	logic                     sel_low;
	logic                     sel_high;
	logic                     sel_any;
	logic [CAREGS_DATA_W-1:0] rd_sel;

	assign sel_low  = addr_is(reg_addr_in, CAREGS_OFF_LOW);
	assign sel_high = addr_is(reg_addr_in, CAREGS_OFF_HIGH);
	assign sel_any  = addr_is(reg_addr_in, CAREGS_OFF_ANY);

	// Unmapped addresses fall through as all zeros
	assign rd_sel = gate_byte(sel_low, low_view)
	              | gate_byte(sel_high, high_view)
	              | gate_byte(sel_any, any_view);

	// ==========================================================
	// Read data register

	logic [CAREGS_DATA_W-1:0] rdata_r;
	logic [CAREGS_DATA_W-1:0] rdata_nxt;

	// Held until the next read strobe
	assign rdata_nxt = reg_rd_in ? rd_sel : rdata_r;

	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
			rdata_r <= CAREGS_RESET_VAL;
		else
			rdata_r <= rdata_nxt;
	end

	// ==========================================================
	// Outputs

	assign reg_rdata_out    = rdata_r;
	assign chan_any_hit_out = any_flags;

endmodule : caregs_top

/* caregs_cmp_model.sv */
// Comparator model raising low and high hits
`timescale 1ns/1ps
module caregs_cmp
(
	// Conversion strobe and result
	input  wire logic       conv_valid_in,
	input  wire logic [7:0] sample_in,
	// Threshold hits
	output logic            low_hit_out,
	output logic            high_hit_out
);
	localparam logic [7:0] LOW_LIMIT  = 8'h40;
	localparam logic [7:0] HIGH_LIMIT = 8'hc0;

	assign low_hit_out  = conv_valid_in && (sample_in < LOW_LIMIT);
	assign high_hit_out = conv_valid_in && (sample_in > HIGH_LIMIT);
endmodule : caregs_cmp

/* caregs_top_asserts.sv */
// Checker for the alert flag bank
`timescale 1ns/1ps
module caregs_chk
(
	// Clock and reset
	input  wire logic       sys_clk_in,
	input  wire logic       rst_in,
	// Comparator side
	input  wire logic       conv_done_in,
	input  wire logic [2:0] input_channel_in,
	input  wire logic       chan_low_hit_in,
	input  wire logic       chan_high_hit_in,
	// Register port
	input  wire logic       reg_rd_in,
	input  wire logic [7:0] reg_addr_in,
	input  wire logic [7:0] reg_rdata_out,
	// Live flags
	input  wire logic [7:0] chan_any_hit_out
);
	logic       any_hit;
	logic [7:0] keep_mask;

	assign any_hit   = chan_low_hit_in | chan_high_hit_in;
	assign keep_mask = ~(8'h01 << input_channel_in);

	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (rst_in);

	flag_set_a: assert property (
		conv_done_in && any_hit |=> chan_any_hit_out[$past(input_channel_in)])
		else $error("combined flag not set");
	flag_clear_a: assert property (
		conv_done_in && !any_hit
		|=> !chan_any_hit_out[$past(input_channel_in)])
		else $error("combined flag not cleared");
	other_bits_a: assert property (
		conv_done_in
		|=> ((chan_any_hit_out ^ $past(chan_any_hit_out))
		    & $past(keep_mask)) == 8'h00)
		else $error("other channel flag changed");
	idle_stable_a: assert property (
		!conv_done_in |=> $stable(chan_any_hit_out))
		else $error("flags changed without conversion");
	reset_zero_a: assert property (
		$fell(rst_in)
		|-> chan_any_hit_out == 8'h00 && reg_rdata_out == 8'h00)
		else $error("flags not cleared by reset");
	unmapped_zero_a: assert property (
		reg_rd_in && reg_addr_in > 8'h7e |=> reg_rdata_out == 8'h00)
		else $error("unmapped read not zero");
	any_read_a: assert property (
		reg_rd_in && reg_addr_in == 8'h7e
		|=> reg_rdata_out == $past(chan_any_hit_out))
		else $error("combined register read wrong");
	low_read_a: assert property (
		conv_done_in && chan_low_hit_in ##1 !conv_done_in
		##1 reg_rd_in && reg_addr_in == 8'h7c
		|=> reg_rdata_out[$past(input_channel_in, 3)])
		else $error("low flag read wrong");
	high_read_a: assert property (
		conv_done_in && chan_high_hit_in ##1 !conv_done_in
		##1 reg_rd_in && reg_addr_in == 8'h7d
		|=> reg_rdata_out[$past(input_channel_in, 3)])
		else $error("high flag read wrong");

	cover property (conv_done_in && chan_low_hit_in);
	cover property (conv_done_in && chan_high_hit_in);
	cover property (conv_done_in && !any_hit);
	cover property (reg_rd_in && reg_addr_in > 8'h7e);
endmodule : caregs_chk

bind caregs_top caregs_chk chk_u (.*);

/* caregs_top_bench.sv */
// Bench for the alert flag bank
`timescale 1ns/1ps
module caregs_top_bench;
	// ==========================================================
	// Signals
	localparam int WATCH_CYCLES = 400;

	logic        clk         = 1'b0;
	logic        rst         = 1'b1;
	logic        conv_done   = 1'b0;
	logic        reg_wr      = 1'b0;
	logic        reg_rd      = 1'b0;
	logic [2:0]  chan        = 3'h0;
	logic [7:0]  sample      = 8'h00;
	logic [7:0]  reg_addr    = 8'h00;
	logic [7:0]  reg_wdata   = 8'h00;
	logic [7:0]  rdata;
	logic [7:0]  any_hit;
	wire         low_hit;
	wire         high_hit;
	int          n_fail      = 0;
	int          check_count = 0;
	// Row: channel [26:24], sample [23:16], low [15:8], high [7:0]
	logic [31:0] rows [5]    = '{32'h03100800, 32'h07f00880,
	                             32'h00800880, 32'h03800080,
	                             32'h00000180};

	// ==========================================================
	// Comparator model and design
	caregs_cmp p_u
	(
		.conv_valid_in (conv_done),
		.sample_in     (sample),
		.low_hit_out   (low_hit),
		.high_hit_out  (high_hit)
	);

	caregs_top dut_u
	(
		.sys_clk_in       (clk),
		.rst_in           (rst),
		.conv_done_in     (conv_done),
		.input_channel_in (chan),
		.chan_low_hit_in  (low_hit),
		.chan_high_hit_in (high_hit),
		.reg_addr_in      (reg_addr),
		.reg_wdata_in     (reg_wdata),
		.reg_wr_in        (reg_wr),
		.reg_rd_in        (reg_rd),
		.reg_rdata_out    (rdata),
		.chan_any_hit_out (any_hit)
	);

	initial
	begin
		forever #2.5 clk = ~clk;
	end

	// ==========================================================
	// Tasks
	task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
	begin
		check_count++;
		if (got !== exp)
		begin
			$display("wrong value at %0t: got %h expected %h",
			         $time, got, exp);
			n_fail++;
		end
	end
	endtask : check_byte

	task automatic read_reg(input logic [7:0] addr, input logic [7:0] exp);
	begin
		@(posedge clk);
		reg_rd   <= 1'b1;
		reg_addr <= addr;
		@(posedge clk);
		reg_rd   <= 1'b0;
		#1;
		check_byte(rdata, exp);
	end
	endtask : read_reg

	task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
	begin
		@(posedge clk);
		reg_wr    <= 1'b1;
		reg_addr  <= addr;
		reg_wdata <= data;
		@(posedge clk);
		reg_wr    <= 1'b0;
	end
	endtask : write_reg

	task automatic convert(input logic [2:0] ch, input logic [7:0] value);
	begin
		@(posedge clk);
		conv_done <= 1'b1;
		chan      <= ch;
		sample    <= value;
		@(posedge clk);
		conv_done <= 1'b0;
	end
	endtask : convert

	task automatic complete_run;
	begin
		$display("checks %0d fails %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	end
	endtask : complete_run

	// ==========================================================
	// Watchdog
	initial
	begin
		repeat (WATCH_CYCLES) @(posedge clk);
		n_fail++;
		complete_run();
	end

	// ==========================================================
	// Tests
	initial
	begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		foreach (rows[i])
		begin
			convert(rows[i][26:24], rows[i][23:16]);
			read_reg(8'h7c, rows[i][15:8]);
			read_reg(8'h7d, rows[i][7:0]);
			check_byte(any_hit, rows[i][15:8] | rows[i][7:0]);
			$display("row %0d done", i);
		end
		convert(3'h5, 8'hff);
		read_reg(8'h7d, 8'ha0);
		write_reg(8'h7c, 8'hff);
		write_reg(8'h7d, 8'h00);
		read_reg(8'h7c, 8'h01);
		read_reg(8'h7e, 8'ha1);
		read_reg(8'h7f, 8'h00);
		$display("hand tests done");
		@(posedge clk);
		rst <= 1'b1;
		@(posedge clk);
		rst <= 1'b0;
		read_reg(8'h7e, 8'h00);
		check_byte(any_hit, 8'h00);
		$display("reset test done");
		complete_run();
	end
endmodule : caregs_top_bench
